// File: core/cefs_params.svh
`ifndef CEFS_PARAMS_SVH
`define CEFS_PARAMS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define CEFS_OFS_OPERATION   8'h01
`define CEFS_OFS_ENSRC       8'h02
`define CEFS_OPERATION_RST   8'h00
`define CEFS_ENSRC_RST       8'h16
`define CEFS_OP_ON_BIT       7
// ----------------------------------------
// enable configuration codes
// ----------------------------------------
`define CEFS_CFG_PIN_ONLY    8'h16
`define CEFS_CFG_BIT_ONLY    8'h1A
`define CEFS_CFG_BOTH        8'h1E
`define CEFS_CFG_ALWAYS_OFF  8'h12
`define CEFS_CFG_HI_MASK     8'hF0
// ----------------------------------------
// timing, 10 MHz clock
// ----------------------------------------
`define CEFS_CLK_HZ          10000000
`define CEFS_UV_FILT_US      1000
`define CEFS_UV_ARM_US       1500
`define CEFS_HICCUP_US       16000
`define CEFS_PG_DELAY_US     1000
`define CEFS_US_TO_CYC(us)   (((us) * (`CEFS_CLK_HZ / 1000000)))
`endif

// File: core/cefs_pkg.sv
package cefs_pkg;
  typedef enum logic [2:0] {
    CEFS_OFF, CEFS_SOFTSTART, CEFS_RUN, CEFS_SINK, CEFS_HICCUP
  } cefs_state_t;
endpackage

// File: core/cefs_supervisor.sv
`timescale 1ns/100ps
`include "cefs_params.svh"
module cefs_supervisor #(
  parameter int UV_FILT_CYC  = `CEFS_US_TO_CYC(`CEFS_UV_FILT_US),
  parameter int UV_ARM_CYC   = `CEFS_US_TO_CYC(`CEFS_UV_ARM_US),
  parameter int HICCUP_CYC   = `CEFS_US_TO_CYC(`CEFS_HICCUP_US),
  parameter int PG_DELAY_CYC = `CEFS_US_TO_CYC(`CEFS_PG_DELAY_US)
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               remote_enable_pin,
  input  wire logic               wr_en,
  input  wire logic [7:0]         wr_addr,
  input  wire logic [7:0]         wr_data,
  input  wire logic [7:0]         rd_addr,
  output logic      [7:0]         rd_data,
  input  wire logic               clear_faults,
  input  wire logic               supply_ok,
  input  wire logic               temp_over_shutdown,
  input  wire logic               temp_below_turnon,
  input  wire logic               fb_below_uv,
  input  wire logic               fb_above_ov,
  input  wire logic               current_limit,
  input  wire logic               softstart_done,
  input  wire logic               ready_line_in,
  output logic                    converter_on,
  output logic                    sink_mode,
  output logic                    softstart_go,
  output logic                    output_ready_flag_oe,
  output logic                    fault_alert_line_n,
  output cefs_pkg::cefs_state_t   state_out
);
  import cefs_pkg::*;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  operation_control, next_operation_control;
  logic [7:0]  enable_source_config, next_enable_source_config;
  logic        uv_flag, ov_flag, ot_flag, lock_flag;
  logic        next_uv_flag, next_ov_flag, next_ot_flag, next_lock_flag;
  logic        ot_active, next_ot_active;
  logic [7:0]  next_rd_data;
  always_comb begin
    next_operation_control    = operation_control;
    next_enable_source_config = enable_source_config;
    if (wr_en && wr_addr == `CEFS_OFS_OPERATION) begin
      next_operation_control = wr_data;
    end
    if (wr_en && wr_addr == `CEFS_OFS_ENSRC) begin
      next_enable_source_config = wr_data;
    end
    unique case (rd_addr)
      `CEFS_OFS_OPERATION: next_rd_data = operation_control;
      `CEFS_OFS_ENSRC:     next_rd_data = enable_source_config;
      default:             next_rd_data = {4'h0, lock_flag, ot_flag, ov_flag, uv_flag};
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operation_control    <= `CEFS_OPERATION_RST;
      enable_source_config <= `CEFS_ENSRC_RST;
      rd_data              <= 8'h00;
    end else begin
      operation_control    <= next_operation_control;
      enable_source_config <= next_enable_source_config;
      rd_data              <= next_rd_data;
    end
  end
  // ----------------------------------------
  // enable decision
  // ----------------------------------------
  logic en_req;
  logic op_on;
  always_comb begin
    op_on = operation_control[`CEFS_OP_ON_BIT];
    if ((enable_source_config & `CEFS_CFG_HI_MASK) == 8'h00) begin
      en_req = 1'b1;
    end else if (enable_source_config == `CEFS_CFG_BIT_ONLY) begin
      en_req = op_on;
    end else if (enable_source_config == `CEFS_CFG_BOTH) begin
      en_req = op_on & remote_enable_pin;
    end else if (enable_source_config == `CEFS_CFG_ALWAYS_OFF) begin
      en_req = 1'b0;
    end else begin
      en_req = remote_enable_pin; // pin only, also for unknown codes with a nonzero high nibble
    end
  end
  // ----------------------------------------
  // timers
  // ----------------------------------------
  cefs_timer_if hic_t ();
  cefs_timer_if aux_t ();
  cefs_timer u_hic (.clk(clk), .rst_n(rst_n), .t(hic_t));
  cefs_timer u_aux (.clk(clk), .rst_n(rst_n), .t(aux_t));
  // ----------------------------------------
  // protection state machine
  // ----------------------------------------
  cefs_state_t st, next_st;
  logic        uv_armed, next_uv_armed;
  logic        uv_timing, next_uv_timing;
  logic        pg, next_pg;
  logic        pg_wait, next_pg_wait;
  logic        fault_evt;
  logic        stop;
  always_comb begin
    next_st        = st;
    next_uv_armed  = uv_armed;
    next_uv_timing = uv_timing;
    next_pg        = pg;
    next_pg_wait   = pg_wait;
    next_ot_active = ot_active;
    hic_t.load     = 1'b0;
    hic_t.count    = 32'(HICCUP_CYC);
    aux_t.load     = 1'b0;
    aux_t.count    = 32'(PG_DELAY_CYC);
    fault_evt      = 1'b0;
    if (temp_over_shutdown) begin
      next_ot_active = 1'b1;
    end else if (temp_below_turnon) begin
      next_ot_active = 1'b0; // automatic restart
    end
    // stop on supply loss, over-temperature or enable request low
    stop = !supply_ok || next_ot_active || !en_req;
    unique case (st)
      CEFS_OFF: begin
        if (!stop && !fb_above_ov) begin
          next_st = CEFS_SOFTSTART; // no start while over-voltage
        end
      end
      CEFS_SOFTSTART: begin
        next_uv_armed = 1'b0;
        if (softstart_done) begin
          next_st      = CEFS_RUN;
          aux_t.load   = 1'b1;
          next_pg_wait = 1'b1;
        end
      end
      CEFS_RUN: begin
        if (pg_wait && aux_t.expired) begin
          next_pg_wait = 1'b0;
          next_pg      = 1'b1;
          aux_t.load   = 1'b1;
          aux_t.count  = 32'(UV_ARM_CYC - PG_DELAY_CYC);
        end else if (!pg_wait && !uv_armed && aux_t.expired) begin
          next_uv_armed = 1'b1;
        end
        if (uv_armed && fb_below_uv && !uv_timing) begin
          next_uv_timing = 1'b1;
          aux_t.load     = 1'b1;
          aux_t.count    = 32'(UV_FILT_CYC);
        end else if (uv_timing && !fb_below_uv) begin
          next_uv_timing = 1'b0;
        end
        if (fb_above_ov) begin
          next_st = CEFS_SINK;
          fault_evt = 1'b1;
        end else if ((uv_timing && fb_below_uv && aux_t.expired) ||
                     (current_limit && fb_below_uv)) begin
          next_st    = CEFS_HICCUP;
          hic_t.load = 1'b1;
          fault_evt  = 1'b1;
        end else if (pg && !ready_line_in) begin
          next_st    = CEFS_HICCUP;
          hic_t.load = 1'b1;
          fault_evt  = 1'b1;
        end
      end
      CEFS_SINK: begin
        if (fb_below_uv) begin
          next_st    = CEFS_HICCUP;
          hic_t.load = 1'b1;
        end else if (!fb_above_ov) begin
          next_st    = CEFS_HICCUP;
          hic_t.load = 1'b1;
        end
      end
      CEFS_HICCUP: begin
        if (hic_t.expired) begin
          next_st = CEFS_OFF; // restart path, still blocked by over-voltage
        end
      end
      default: next_st = CEFS_OFF;
    endcase
    if (stop && st != CEFS_OFF && st != CEFS_HICCUP) begin
      next_st   = CEFS_OFF;
      fault_evt = fault_evt || !supply_ok || next_ot_active;
    end
    if (next_st != CEFS_RUN) begin
      next_uv_timing = 1'b0;
      next_pg_wait   = 1'b0;
    end
    if (fault_evt || next_st != CEFS_RUN) begin
      next_pg = 1'b0; // latched low until next soft start
    end
    if (!supply_ok) begin
      next_pg = 1'b0;
    end
  end
  // ----------------------------------------
  // sticky flags, set wins over clear
  // ----------------------------------------
  logic        next_converter_on, next_sink_mode, next_softstart_go;
  logic        next_output_ready_flag_oe, next_fault_alert_line_n;
  always_comb begin
    next_uv_flag   = (uv_flag   && !clear_faults) ||
                     (st == CEFS_RUN && next_st == CEFS_HICCUP);
    next_ov_flag   = (ov_flag   && !clear_faults) || fb_above_ov;
    next_ot_flag   = (ot_flag   && !clear_faults) || temp_over_shutdown;
    next_lock_flag = (lock_flag && !clear_faults) || !supply_ok;
    next_converter_on         = (next_st == CEFS_SOFTSTART) || (next_st == CEFS_RUN);
    next_sink_mode            = (next_st == CEFS_SINK);
    next_softstart_go         = (next_st == CEFS_SOFTSTART);
    next_output_ready_flag_oe = !next_pg; // open drain pulls low
    next_fault_alert_line_n   = !(next_uv_flag || next_ov_flag ||
                                  next_ot_flag || next_lock_flag);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st                   <= CEFS_OFF;
      uv_armed             <= 1'b0;
      uv_timing            <= 1'b0;
      pg                   <= 1'b0;
      pg_wait              <= 1'b0;
      ot_active            <= 1'b0;
      uv_flag              <= 1'b0;
      ov_flag              <= 1'b0;
      ot_flag              <= 1'b0;
      lock_flag            <= 1'b0;
      converter_on         <= 1'b0;
      sink_mode            <= 1'b0;
      softstart_go         <= 1'b0;
      output_ready_flag_oe <= 1'b1;
      fault_alert_line_n   <= 1'b1;
      state_out            <= CEFS_OFF;
    end else begin
      st                   <= next_st;
      uv_armed             <= next_uv_armed;
      uv_timing            <= next_uv_timing;
      pg                   <= next_pg;
      pg_wait              <= next_pg_wait;
      ot_active            <= next_ot_active;
      uv_flag              <= next_uv_flag;
      ov_flag              <= next_ov_flag;
      ot_flag              <= next_ot_flag;
      lock_flag            <= next_lock_flag;
      converter_on         <= next_converter_on;
      sink_mode            <= next_sink_mode;
      softstart_go         <= next_softstart_go;
      output_ready_flag_oe <= next_output_ready_flag_oe;
      fault_alert_line_n   <= next_fault_alert_line_n;
      state_out            <= next_st;
    end
  end
endmodule // cefs_supervisor

// File: core/cefs_timer.sv
`timescale 1ns/100ps
module cefs_timer (
  input wire logic clk,
  input wire logic rst_n,
  cefs_timer_if.tmr t
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_exp;
  logic        exp_q;
  always_comb begin
    next_cnt = cnt;
    next_exp = 1'b0;
    if (t.load) begin
      next_cnt = t.count;
    end else if (cnt != 32'h0) begin
      next_cnt = cnt - 32'h1;
      next_exp = (cnt == 32'h1);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= 32'h0;
      exp_q <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      exp_q <= next_exp;
    end
  end
  assign t.expired = exp_q;
endmodule // cefs_timer

// File: core/cefs_timer_if.sv
`timescale 1ns/100ps
interface cefs_timer_if;
  logic        load;
  logic [31:0] count;
  logic        expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface

// File: dv/cefs_host_model.sv
`timescale 1ns/100ps
module cefs_host_model (
  input  wire logic en_req,
  input  wire logic phase_fault,
  input  wire logic oe,
  output logic      remote_enable_pin,
  output logic      ready_line_in
);
  // full logic levels only, never left floating
  assign remote_enable_pin = en_req;
  // pull-up on the shared line, any phase may pull it low
  assign ready_line_in = !(oe || phase_fault);
endmodule // cefs_host_model

// File: dv/cefs_monitor.sv
`timescale 1ns/100ps
module cefs_monitor (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  remote_enable_pin,
  input wire logic                  wr_en,
  input wire logic [7:0]            wr_addr,
  input wire logic [7:0]            wr_data,
  input wire logic                  clear_faults,
  input wire logic                  supply_ok,
  input wire logic                  temp_over_shutdown,
  input wire logic                  fb_above_ov,
  input wire logic                  fb_below_uv,
  input wire logic                  converter_on,
  input wire logic                  sink_mode,
  input wire logic                  output_ready_flag_oe,
  input wire logic                  fault_alert_line_n,
  input wire cefs_pkg::cefs_state_t state_out
);
  import cefs_pkg::*;
  logic [7:0] cfg;
  // ----------------------------------------
  // shadow of the enable configuration
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cfg <= 8'h16;
    else if (wr_en && wr_addr == 8'h02) cfg <= wr_data;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  supply_clamp_a: assert property (!supply_ok |=> output_ready_flag_oe)
    else $error("ready line not clamped on supply loss");
  softstart_ready_a: assert property (state_out == CEFS_SOFTSTART &&
    $past(state_out) == CEFS_SOFTSTART |-> output_ready_flag_oe) else $error("ready early");
  ready_delay_a: assert property ($fell(output_ready_flag_oe) |->
    $past(state_out, 2) == CEFS_RUN) else $error("ready released without delay");
  hiccup_latch_a: assert property (state_out == CEFS_HICCUP |=> output_ready_flag_oe)
    else $error("ready not latched low after fault");
  thermal_off_a: assert property (temp_over_shutdown |-> ##[1:2] !converter_on)
    else $error("no thermal shutdown");
  ov_sink_a: assert property (state_out == CEFS_RUN && fb_above_ov |-> ##[1:2] sink_mode)
    else $error("no sink on over-voltage");
  sink_ready_a: assert property (sink_mode && $past(sink_mode) |-> output_ready_flag_oe)
    else $error("ready high while sinking");
  alert_set_a: assert property ($rose(sink_mode) |-> ##[0:2] !fault_alert_line_n)
    else $error("alert not raised");
  cfg_off_a: assert property (cfg == 8'h12 && $past(cfg) == 8'h12 |=> !converter_on)
    else $error("output on with always-off code");
  pin_low_a: assert property (cfg == 8'h16 && !remote_enable_pin &&
    !$past(remote_enable_pin) |=> !converter_on) else $error("output on with pin low");
  clear_flags_a: assert property (clear_faults && supply_ok && !temp_over_shutdown &&
    !fb_above_ov && !fb_below_uv |=> fault_alert_line_n) else $error("alert not cleared");
endmodule // cefs_monitor
bind cefs_supervisor cefs_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .remote_enable_pin(remote_enable_pin), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
  .clear_faults(clear_faults), .supply_ok(supply_ok), .temp_over_shutdown(temp_over_shutdown),
  .fb_above_ov(fb_above_ov), .fb_below_uv(fb_below_uv), .converter_on(converter_on),
  .sink_mode(sink_mode), .output_ready_flag_oe(output_ready_flag_oe),
  .fault_alert_line_n(fault_alert_line_n), .state_out(state_out));

// File: dv/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
`define WAITC(c) begin for (int k = 0; k < 400 && !(c); k++) tick(1); if (!(c)) begin \
  $display("CHECK FAILED wait exp 1 got 0"); err_total++; final_report(); end end
module tb;
  import cefs_pkg::*;
  localparam int UF = 5, UA = 10, HC = 20, PG = 3;
  logic clk = 1'h0, rst_n = 1'h0, en_req = 1'h0, phase_fault = 1'h0, wr_en = 1'h0;
  logic clear_faults = 1'h0, supply_ok = 1'h1, t_over = 1'h0, t_below = 1'h1;
  logic uv = 1'h0, ov = 1'h0, ilim = 1'h0, ss_done = 1'h0;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, rd_addr = 8'h00, rd_data, lf = 8'h54;
  logic pin, rline, conv_on, sink, ss_go, oe, alert_n;
  // last code is unknown and must act as pin only
  logic [7:0] codes [6] = '{8'h16, 8'h1A, 8'h1E, 8'h12, 8'h05, 8'h33};
  cefs_state_t st;
  int err_total = 0, cmp_count = 0, n;
  always #50 clk = ~clk;
  cefs_host_model host (.en_req(en_req), .phase_fault(phase_fault), .oe(oe),
    .remote_enable_pin(pin), .ready_line_in(rline));
  cefs_supervisor #(.UV_FILT_CYC(UF), .UV_ARM_CYC(UA), .HICCUP_CYC(HC), .PG_DELAY_CYC(PG)) dut (
    .clk(clk), .rst_n(rst_n), .remote_enable_pin(pin), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .clear_faults(clear_faults),
    .supply_ok(supply_ok), .temp_over_shutdown(t_over), .temp_below_turnon(t_below),
    .fb_below_uv(uv), .fb_above_ov(ov), .current_limit(ilim), .softstart_done(ss_done),
    .ready_line_in(rline), .converter_on(conv_on), .sink_mode(sink), .softstart_go(ss_go),
    .output_ready_flag_oe(oe), .fault_alert_line_n(alert_n), .state_out(st));
  task tick(int c); repeat (c) @(posedge clk); #1; endtask
  task wr(logic [7:0] a, logic [7:0] d);
    wr_addr = a; wr_data = d; wr_en = 1'h1; tick(1); wr_en = 1'h0; tick(1);
  endtask
  task rd(logic [7:0] a, logic [7:0] e, string nm);
    rd_addr = a;
    tick(1);
    `CHK(nm, e, rd_data)
  endtask
  task clr; clear_faults = 1'h1; tick(1); clear_faults = 1'h0; tick(1); endtask
  function logic [7:0] nxt(logic [7:0] x); return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]}; endfunction
  // expected output enable for a code, pin level and on/off bit
  function logic exp_on(logic [7:0] c, logic p, logic b);
    case (c)
      8'h16: return p;
      8'h1A: return b;
      8'h1E: return p && b;
      8'h12: return 1'h0;
      default: return (c[7:4] == 4'h0) ? 1'h1 : p;
    endcase
  endfunction
  task final_report;
    $display("counts: %0d mismatches, %0d comparisons", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin #3000000; err_total++; final_report(); end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    rd(8'h01, 8'h00, "operation reset");
    rd(8'h02, 8'h16, "config reset");
    rd(8'h03, 8'h00, "flags reset");
    lf = nxt(lf); wr(8'h05, lf); rd(8'h02, 8'h16, "unmapped write");
    $display("test registers done");
    en_req = 1'h1; `WAITC(ss_go === 1'h1) tick(3); `CHK("ready in soft start", 1'h1, oe)
    ss_done = 1'h1; `WAITC(st === CEFS_RUN) n = 0;
    while (oe !== 1'h0 && n < 50) begin tick(1); n++; end
    `CHK("ready delay", 1'h1, n inside {[PG - 1:PG + 1]})
    for (int i = 0; i < 18; i++) begin
      lf = nxt(lf);
      wr(8'h02, codes[i % 6]);
      wr(8'h01, {lf[0], 7'h00});
      en_req = lf[1];
      tick(4);
      `CHK("enable", exp_on(codes[i % 6], lf[1], lf[0]), conv_on)
      rd(8'h01, {lf[0], 7'h00}, "on bit");
    end
    $display("test enable codes done");
    wr(8'h02, 8'h16); en_req = 1'h1; `WAITC(oe === 1'h0)
    ov = 1'h1; `WAITC(sink === 1'h1) tick(2); `CHK("ready on ov", 1'h1, oe)
    `CHK("alert", 1'h0, alert_n)
    rd(8'h03, 8'h02, "ov flag");
    tick(30);
    `CHK("sink held under ov", CEFS_SINK, st)
    uv = 1'h1;
    `WAITC(st === CEFS_HICCUP)
    uv = 1'h0;
    n = 0;
    while (st === CEFS_HICCUP && n < 400) begin
      tick(1);
      n++;
    end
    `CHK("hiccup length", 1'h1, n inside {[HC - 1:HC + 2]})
    tick(30);
    `CHK("no start under ov", CEFS_OFF, st)
    ov = 1'h0;
    `WAITC(st === CEFS_RUN)
    clr();
    `CHK("alert cleared", 1'h1, alert_n)
    rd(8'h03, 8'h00, "flags cleared");
    $display("test over-voltage done");
    `WAITC(oe === 1'h0) t_over = 1'h1; t_below = 1'h0; tick(3);
    `CHK("thermal off", 1'h0, conv_on)
    rd(8'h03, 8'h04, "ot flag");
    t_over = 1'h0; tick(8); `CHK("hysteresis", 1'h0, conv_on)
    t_below = 1'h1; `WAITC(conv_on === 1'h1) clr();
    $display("test thermal done");
    `WAITC(oe === 1'h0) uv = 1'h1; tick(UF + 3); `CHK("uv not armed", CEFS_RUN, st)
    `WAITC(st === CEFS_HICCUP) ilim = 1'h1;
    `WAITC(st === CEFS_SOFTSTART) `WAITC(st === CEFS_HICCUP)
    uv = 1'h0; ilim = 1'h0; `WAITC(oe === 1'h0) rd(8'h03, 8'h01, "uv flag");
    $display("test short circuit done");
    clr(); phase_fault = 1'h1; tick(3); `CHK("phase fault", 1'h1, oe)
    phase_fault = 1'h0; `WAITC(oe === 1'h0) clr();
    supply_ok = 1'h0; tick(2); `CHK("supply clamp", 1'h1, oe)
    rd(8'h03, 8'h08, "lockout flag");
    clr();
    rd(8'h03, 8'h08, "set wins over clear");
    supply_ok = 1'h1;
    $display("test supply done");
    final_report();
  end
endmodule // tb
